/* File: hdl/pbarb_pkg.sv */
// Package for the processor bus address arbitration block.
// Assumes both ends share one processor bus clock and active-low bus lines.
package pbarb_pkg;
    localparam int ADDR_W = 32;
    localparam int PAR_W = 4;
    localparam int EXT_MASTERS = 2;
    localparam logic ARB_INTERNAL = 1'b1;
    localparam logic LINE_IDLE_N = 1'b1;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [3:0] PAR_RESET = 4'h0;
    localparam int DATA_TENURE_CYCLES = 4;
    localparam int ACK_DELAY_CYCLES = 1;

    typedef enum logic [2:0] {
        PBARB_IDLE = 3'b000,
        PBARB_REQ = 3'b001,
        PBARB_ADDR = 3'b010,
        PBARB_DATA = 3'b011,
        PBARB_RETRY = 3'b100
    } pbarb_state_e;

    // Odd parity per address byte, byte 0 holding the most significant bits.
    function automatic logic [3:0] pbarb_parity(input logic [31:0] a);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ~(^a[31-8*i -: 8]);
        end
        return p;
    endfunction
endpackage

/* File: hdl/pbarb_if.sv */
// Interface for the shared processor address bus between the bridge and a far master.
// Resolves every line driven from both ends as wired pull-up: a line is low only while some enabled driver pulls it.
`timescale 1ns/1ns
interface pbarb_if;
    import pbarb_pkg::*;
    logic [31:0] dev_addr_o, dev_addr_oe, far_addr_o, far_addr_oe, proc_address;
    logic [3:0] dev_par_o, dev_par_oe, far_par_o, far_par_oe, addr_parity;
    logic dev_ack_o, dev_ack_oe, far_ack_o, far_ack_oe, addr_ack_n;
    logic dev_rty_o, dev_rty_oe, far_rty_o, far_rty_oe, addr_retry_n;
    logic dev_abb_o, dev_abb_oe, far_abb_o, far_abb_oe, addr_bus_busy_n;
    logic dev_dbb_o, dev_dbb_oe, far_dbb_o, far_dbb_oe, data_bus_busy_n;
    logic dev_ci_o, dev_ci_oe, far_ci_o, far_ci_oe, cache_inhibit_n;
    logic dev_gnt1_o, dev_gnt1_oe, far_gnt1_o, far_gnt1_oe, addr_grant1_n;
    logic dev_req1_o, dev_req1_oe, far_req1_o, far_req1_oe, addr_request1_n;
    logic [1:0] addr_grant_ext_n, addr_request_ext_n;

    function automatic logic res(input logic d0, input logic e0, input logic d1, input logic e1);
        return (e0 ? d0 : 1'b1) & (e1 ? d1 : 1'b1);
    endfunction

    for (genvar i = 0; i < 32; i++) begin : g_a
        assign proc_address[i] = res(dev_addr_o[i], dev_addr_oe[i], far_addr_o[i], far_addr_oe[i]);
    end
    for (genvar i = 0; i < 4; i++) begin : g_p
        assign addr_parity[i] = res(dev_par_o[i], dev_par_oe[i], far_par_o[i], far_par_oe[i]);
    end
    assign addr_ack_n = res(dev_ack_o, dev_ack_oe, far_ack_o, far_ack_oe);
    assign addr_retry_n = res(dev_rty_o, dev_rty_oe, far_rty_o, far_rty_oe);
    assign addr_bus_busy_n = res(dev_abb_o, dev_abb_oe, far_abb_o, far_abb_oe);
    assign data_bus_busy_n = res(dev_dbb_o, dev_dbb_oe, far_dbb_o, far_dbb_oe);
    assign cache_inhibit_n = res(dev_ci_o, dev_ci_oe, far_ci_o, far_ci_oe);
    assign addr_grant1_n = res(dev_gnt1_o, dev_gnt1_oe, far_gnt1_o, far_gnt1_oe);
    assign addr_request1_n = res(dev_req1_o, dev_req1_oe, far_req1_o, far_req1_oe);

    modport dev (
        input proc_address, addr_parity, addr_ack_n, addr_retry_n, addr_bus_busy_n,
        input data_bus_busy_n, cache_inhibit_n, addr_grant1_n, addr_request1_n, addr_request_ext_n,
        output dev_addr_o, dev_addr_oe, dev_par_o, dev_par_oe, dev_ack_o, dev_ack_oe,
        output dev_rty_o, dev_rty_oe, dev_abb_o, dev_abb_oe, dev_dbb_o, dev_dbb_oe,
        output dev_ci_o, dev_ci_oe, dev_gnt1_o, dev_gnt1_oe, dev_req1_o, dev_req1_oe,
        output addr_grant_ext_n
    );
    modport far (
        input proc_address, addr_parity, addr_ack_n, addr_retry_n, addr_bus_busy_n,
        input data_bus_busy_n, cache_inhibit_n, addr_grant1_n, addr_request1_n, addr_grant_ext_n,
        output far_addr_o, far_addr_oe, far_par_o, far_par_oe, far_ack_o, far_ack_oe,
        output far_rty_o, far_rty_oe, far_abb_o, far_abb_oe, far_dbb_o, far_dbb_oe,
        output far_ci_o, far_ci_oe, far_gnt1_o, far_gnt1_oe, far_req1_o, far_req1_oe,
        output addr_request_ext_n
    );
endinterface

/* File: hdl/pbarb_far.sv */
// Far master end: one external master using request line 1, plus a slave that answers
// device tenures. Mirrors the bridge's arbiter role from arb_internal.
// Assumes a single bus clock shared with the bridge.
`timescale 1ns/1ns
module pbarb_far (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Mode, same strap value as the bridge
    input wire logic arb_internal,
    // User request side
    input wire logic usr_req,
    input wire logic [31:0] usr_addr,
    input wire logic usr_ci,
    input wire logic usr_retry,
    output logic usr_done,
    output logic usr_retried,
    // Bus side
    pbarb_if.far bus
);
    import pbarb_pkg::*;

    pbarb_state_e st_q, st_d;
    logic [31:0] addr_q;
    logic ci_q, done_q, rtd_q, ack_q, rty_q, gnt_q;
    logic [2:0] cnt_q;
    logic [1:0] ackd_q;

    // As outside arbiter the far end keeps the bus for itself whenever it is not
    // granting the bridge.
    wire granted = arb_internal ? ~bus.addr_grant1_n : ~gnt_q;
    wire ack_seen = ~bus.addr_ack_n;
    wire retry_seen = ~bus.addr_retry_n;
    wire owns_addr = (st_q == PBARB_ADDR);
    wire owns_data = (st_q == PBARB_DATA);
    // The far end acts as slave when the bridge runs a tenure it did not start.
    wire dev_tenure = ~bus.addr_bus_busy_n & ~owns_addr;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            PBARB_IDLE: if (usr_req) st_d = PBARB_REQ;
            PBARB_REQ: if (granted && bus.addr_bus_busy_n) st_d = PBARB_ADDR;
            PBARB_ADDR: if (ack_seen) st_d = retry_seen ? PBARB_RETRY : PBARB_DATA; // RULE2 RULE5
            PBARB_DATA: if (cnt_q == 3'(DATA_TENURE_CYCLES - 1)) st_d = PBARB_IDLE;
            PBARB_RETRY: st_d = PBARB_REQ; // RULE5
            default: st_d = PBARB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin // RULE12
        if (!arst_n) begin
            st_q <= PBARB_IDLE;
            addr_q <= ADDR_RESET;
            ci_q <= 1'b0;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            rtd_q <= 1'b0;
            ackd_q <= 2'h0;
            ack_q <= 1'b0;
            rty_q <= 1'b0;
            gnt_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == PBARB_IDLE && usr_req) begin
                addr_q <= usr_addr;
                ci_q <= usr_ci;
            end
            cnt_q <= owns_data ? cnt_q + 3'h1 : 3'h0;
            done_q <= owns_data && st_d == PBARB_IDLE;
            rtd_q <= st_q == PBARB_RETRY;
            ackd_q <= dev_tenure ? (ackd_q == 2'h2 ? ackd_q : ackd_q + 2'h1) : 2'h0;
            ack_q <= dev_tenure && ackd_q == 2'(ACK_DELAY_CYCLES); // RULE1
            rty_q <= dev_tenure && ackd_q == 2'(ACK_DELAY_CYCLES) && usr_retry;
            // Acting as outside arbiter: grant the bridge whenever it asks and we are quiet.
            gnt_q <= ~bus.addr_request1_n && st_q == PBARB_IDLE && ~usr_req;
        end
    end

    assign usr_done = done_q;
    assign usr_retried = rtd_q;
    assign bus.far_addr_o = addr_q;
    assign bus.far_addr_oe = {32{owns_addr}};
    assign bus.far_par_o = pbarb_parity(addr_q); // RULE4
    assign bus.far_par_oe = {4{owns_addr}};
    assign bus.far_abb_o = 1'b0;
    assign bus.far_abb_oe = owns_addr;
    assign bus.far_dbb_o = 1'b0;
    assign bus.far_dbb_oe = owns_data; // RULE13
    assign bus.far_ci_o = ~ci_q;
    assign bus.far_ci_oe = owns_addr;
    assign bus.far_ack_o = 1'b0;
    assign bus.far_ack_oe = ack_q; // RULE1
    assign bus.far_rty_o = 1'b0;
    assign bus.far_rty_oe = rty_q;
    // Line 1 roles follow the arbiter selection, opposite to the bridge.
    assign bus.far_req1_o = 1'b0;
    assign bus.far_req1_oe = arb_internal && (st_q == PBARB_REQ); // RULE9
    assign bus.far_gnt1_o = 1'b0;
    assign bus.far_gnt1_oe = ~arb_internal && gnt_q; // RULE7
    assign bus.addr_request_ext_n = 2'b11; // RULE10
endmodule

/* File: hdl/pbarb_dev.sv */
// Bridge end of the processor address bus: own master, slave answer and internal arbiter.
// Assumes the arbiter selection strap is stable and bus lines have pull-ups.
// Functional notes
// (RULE1) Slave asserts acknowledge on recognised tenure.
// (RULE2) Tenure ends when acknowledge is sampled.
// (RULE3) Address bus busy while device owns bus.
// (RULE4) Master drives four byte parity bits.
// (RULE5) Retried transaction is reissued later.
// (RULE6) Address driven only while device is master.
// (RULE7) Grant one input under external arbitration.
// (RULE8) Grant one output under internal arbitration.
// (RULE9) Request one direction follows arbiter selection.
// (RULE10) Masters two, three use dedicated lines.
// (RULE11) Master drives cache inhibit per transaction.
// (RULE12) Everything synchronous to one bus clock.
// (RULE13) Data owner asserts data bus busy.
// (RULE14) Active low lines released in reset; the bridge still drives line one per arb_internal and both outside grants high.
`timescale 1ns/1ns
module pbarb_dev #(
    parameter int N_EXT = pbarb_pkg::EXT_MASTERS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Arbiter selection
    input wire logic arb_internal,
    // Own transaction request
    input wire logic usr_req,
    input wire logic [pbarb_pkg::ADDR_W-1:0] usr_addr,
    input wire logic usr_ci,
    input wire logic usr_retry,
    output logic usr_done,
    output logic usr_retried,
    output logic usr_busy,
    // Address seen when acting as slave
    input wire logic [pbarb_pkg::ADDR_W-1:0] slave_base,
    input wire logic [pbarb_pkg::ADDR_W-1:0] slave_mask,
    output logic slave_hit,
    output logic [pbarb_pkg::ADDR_W-1:0] slave_addr,
    output logic slave_parity_err,
    // Bus side
    pbarb_if.dev bus
);
    import pbarb_pkg::*;

    pbarb_state_e st_q, st_d;
    logic [ADDR_W-1:0] addr_q, saddr_q;
    logic ci_q, done_q, rtd_q, hit_q, perr_q, ack_q, rty_q, seen_q;
    logic [2:0] cnt_q;
    logic [2:0] gnt_q, gnt_d;
    logic [1:0] last_q;
    logic busy_q, drv_addr_q, drv_data_q;

    // Internal arbiter request vector: bit 0 external master 1, bits 1..2 masters two and three.
    wire [2:0] ext_req = arb_internal ? {~bus.addr_request_ext_n, ~bus.addr_request1_n} : 3'h0;
    wire own_req = st_q == PBARB_REQ;
    wire bus_quiet = bus.addr_bus_busy_n && gnt_q == 3'h0;
    // Under internal arbitration the bridge wins a tie with an outside request; otherwise both
    // would wait on each other. Outside masters are served once the bridge is not requesting and the address bus is free.
    wire own_grant = arb_internal ? bus_quiet : ~bus.addr_grant1_n; // RULE7
    wire owns_addr = st_q == PBARB_ADDR;
    wire owns_data = st_q == PBARB_DATA;
    wire ack_seen = ~bus.addr_ack_n;
    wire retry_seen = ~bus.addr_retry_n;
    wire tenure = ~bus.addr_bus_busy_n && ~owns_addr;
    wire addr_match = ((bus.proc_address ^ slave_base) & slave_mask) == '0;
    // Only the first cycle of an outside tenure is decoded. A tenure that decodes nowhere
    // gets no answer from this end, so another slave must acknowledge it.
    wire first_look = tenure && !seen_q;
    wire slave_take = first_look && addr_match; // RULE1

    // Rotating priority so no external master starves another.
    // Ties cannot occur: the scan stops at the first requester after the last winner.
    function automatic logic [2:0] pick(input logic [2:0] req, input logic [1:0] last);
        logic [2:0] g;
        g = 3'h0;
        for (int k = 1; k <= 3; k++) begin
            if (g == 3'h0 && req[(int'(last) + k) % 3]) begin
                g[(int'(last) + k) % 3] = 1'b1;
            end
        end
        return g;
    endfunction

    always_comb begin
        gnt_d = gnt_q;
        if (!arb_internal) begin
            gnt_d = 3'h0;
        end else if (gnt_q != 3'h0) begin
            // A grant is held until the winner starts its tenure or drops the request.
            if (!bus.addr_bus_busy_n || (gnt_q & ext_req) == 3'h0) gnt_d = 3'h0;
        end else if (bus.addr_bus_busy_n && !own_req) begin
            gnt_d = pick(ext_req, last_q);
        end
    end

    // One transaction at a time: a request while busy is ignored, so a caller must wait
    // for usr_done before it asks again.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            PBARB_IDLE: if (usr_req) st_d = PBARB_REQ;
            PBARB_REQ: if (own_grant && bus.addr_bus_busy_n) st_d = PBARB_ADDR;
            PBARB_ADDR: if (ack_seen) st_d = retry_seen ? PBARB_RETRY : PBARB_DATA; // RULE2
            PBARB_DATA: if (cnt_q == 3'(DATA_TENURE_CYCLES - 1)) st_d = PBARB_IDLE;
            PBARB_RETRY: st_d = PBARB_REQ; // RULE5
            default: st_d = PBARB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin // RULE12
        if (!arst_n) begin
            st_q <= PBARB_IDLE;
            addr_q <= ADDR_RESET;
            ci_q <= 1'b0;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            rtd_q <= 1'b0;
            gnt_q <= 3'h0;
            last_q <= 2'h0;
        end else begin
            st_q <= st_d;
            // Address held across a retry so the same transaction is reissued.
            if (st_q == PBARB_IDLE && usr_req) begin // RULE5
                addr_q <= usr_addr;
                ci_q <= usr_ci;
            end
            cnt_q <= owns_data ? cnt_q + 3'h1 : 3'h0;
            done_q <= owns_data && st_d == PBARB_IDLE;
            rtd_q <= st_q == PBARB_RETRY;
            gnt_q <= gnt_d;
            if (gnt_d[0]) last_q <= 2'h0;
            else if (gnt_d[1]) last_q <= 2'h1;
            else if (gnt_d[2]) last_q <= 2'h2;
        end
    end

    wire next_addr = st_d == PBARB_ADDR;
    wire next_data = st_d == PBARB_DATA;
    wire next_busy = st_d != PBARB_IDLE;

    // Drive enables come straight from flops, so a decode glitch never briefly fights
    // another master on a shared line.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drv_addr_q <= 1'b0;
            drv_data_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            drv_addr_q <= next_addr; // RULE6
            drv_data_q <= next_data; // RULE13
            busy_q <= next_busy;
        end
    end

    // Slave side: acknowledge once per outside tenure that decodes to this bridge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            saddr_q <= ADDR_RESET;
            hit_q <= 1'b0;
            perr_q <= 1'b0;
            ack_q <= 1'b0;
            rty_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            seen_q <= tenure && !ack_seen ? 1'b1 : 1'b0;
            hit_q <= slave_take;
            ack_q <= slave_take; // RULE1
            rty_q <= slave_take && usr_retry; // RULE5
            // Parity is judged on the first look only; a later change of the lines in the
            // same tenure is not flagged.
            if (first_look) begin
                saddr_q <= bus.proc_address;
                perr_q <= bus.addr_parity != pbarb_parity(bus.proc_address);
            end
        end
    end

    assign usr_done = done_q;
    assign usr_retried = rtd_q;
    assign usr_busy = busy_q;
    assign slave_hit = hit_q;
    assign slave_addr = saddr_q;
    assign slave_parity_err = perr_q;

    // Tenure outputs are enabled from flops only, so reset releases them; the line one enables follow arb_internal.
    assign bus.dev_addr_o = addr_q;
    assign bus.dev_addr_oe = {ADDR_W{drv_addr_q}}; // RULE6 RULE14
    assign bus.dev_par_o = pbarb_parity(addr_q); // RULE4
    assign bus.dev_par_oe = {PAR_W{drv_addr_q}};
    assign bus.dev_abb_o = 1'b0;
    assign bus.dev_abb_oe = drv_addr_q; // RULE3
    assign bus.dev_dbb_o = 1'b0;
    assign bus.dev_dbb_oe = drv_data_q; // RULE13
    assign bus.dev_ci_o = ~ci_q; // RULE11
    assign bus.dev_ci_oe = drv_addr_q;
    // Grant one is always driven under internal arbitration; a released grant reads high.
    assign bus.dev_ack_o = 1'b0;
    assign bus.dev_ack_oe = ack_q;
    assign bus.dev_rty_o = 1'b0;
    assign bus.dev_rty_oe = rty_q;
    assign bus.dev_gnt1_o = ~gnt_q[0];
    assign bus.dev_gnt1_oe = arb_internal; // RULE8
    assign bus.dev_req1_o = ~own_req;
    assign bus.dev_req1_oe = ~arb_internal; // RULE9
    assign bus.addr_grant_ext_n = ~gnt_q[2:1]; // RULE10
endmodule

/* File: bench/pbarb_props.sv */
// Checker for the address tenure lines between the bridge end and the far end.
// Assumes one bus clock and the interface's resolved, active-low lines.
`timescale 1ns/1ns
module pbarb_props (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Resolved lines
    input wire logic [31:0] proc_address,
    input wire logic [3:0] addr_parity,
    input wire logic addr_ack_n,
    input wire logic addr_retry_n,
    input wire logic addr_bus_busy_n,
    input wire logic data_bus_busy_n,
    input wire logic addr_grant1_n,
    // Driver enables
    input wire logic [31:0] dev_addr_oe,
    input wire logic [31:0] far_addr_oe,
    input wire logic dev_abb_oe,
    input wire logic far_abb_oe,
    input wire logic dev_dbb_oe,
    input wire logic dev_ci_oe,
    input wire logic dev_gnt1_oe,
    input wire logic dev_req1_oe
);
    default clocking cb @(posedge clk);
    endclocking
    sequence s_tenure_start;
        $rose(dev_abb_oe) ##0 !addr_bus_busy_n;
    endsequence
    sequence s_dbb_hold;
        !data_bus_busy_n [*4] ##1 data_bus_busy_n;
    endsequence
    // No disable here: the point is what the lines do while reset is held.
    property p_quiet_reset;
        !arst_n |-> dev_addr_oe == 32'h0 && far_addr_oe == 32'h0 && !dev_abb_oe && !far_abb_oe
            && !dev_dbb_oe;
    endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("bus driven in reset");
    property p_one_dir;
        disable iff (!arst_n) dev_gnt1_oe != dev_req1_oe;
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("line one direction wrong");
    property p_addr_owner;
        disable iff (!arst_n) dev_addr_oe != 32'h0 |->
            dev_addr_oe == 32'hffff_ffff && dev_abb_oe && !addr_bus_busy_n;
    endproperty
    a_addr_owner: assert property (p_addr_owner) else $error("address without ownership");
    property p_parity;
        disable iff (!arst_n) dev_addr_oe[0] |-> addr_parity == {~^proc_address[7:0],
            ~^proc_address[15:8], ~^proc_address[23:16], ~^proc_address[31:24]};
    endproperty
    a_parity: assert property (p_parity) else $error("address parity wrong");
    property p_ci;
        disable iff (!arst_n) dev_addr_oe[0] |-> dev_ci_oe;
    endproperty
    a_ci: assert property (p_ci) else $error("cache inhibit not driven");
    property p_tenure_end;
        disable iff (!arst_n) dev_addr_oe[0] && !addr_ack_n |=> !dev_addr_oe[0] && !dev_abb_oe;
    endproperty
    a_tenure_end: assert property (p_tenure_end) else $error("tenure outlived ack");
    property p_busy_end;
        disable iff (!arst_n) $fell(dev_abb_oe) |-> $past(addr_ack_n) == 1'b0;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy dropped early");
    property p_ack;
        disable iff (!arst_n) s_tenure_start |-> ##[1:4] !addr_ack_n;
    endproperty
    a_ack: assert property (p_ack) else $error("tenure not acknowledged");
    property p_dbb;
        disable iff (!arst_n) $fell(data_bus_busy_n) |-> s_dbb_hold;
    endproperty
    a_dbb: assert property (p_dbb) else $error("data busy length wrong");
    property p_retry;
        disable iff (!arst_n) dev_addr_oe[0] && !addr_ack_n && !addr_retry_n |=>
            ##[1:60] $rose(dev_abb_oe);
    endproperty
    a_retry: assert property (p_retry) else $error("retried tenure not reissued");
    property p_grant_in;
        disable iff (!arst_n) $rose(dev_abb_oe) && !dev_gnt1_oe |-> $past(addr_grant1_n) == 1'b0;
    endproperty
    a_grant_in: assert property (p_grant_in) else $error("bridge took bus ungranted");
    property p_grant_out;
        disable iff (!arst_n) $rose(far_abb_oe) && dev_gnt1_oe |-> $past(addr_grant1_n) == 1'b0;
    endproperty
    a_grant_out: assert property (p_grant_out) else $error("far took bus ungranted");
endmodule

/* File: bench/tb_top.sv */
// Bench joining the bridge end and the far end through one bus interface.
// Assumes a 25 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_top;
    import pbarb_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b1;
    logic arb_internal = ARB_INTERNAL;
    logic d_req = 1'b0;
    logic [31:0] d_addr = 32'h0;
    logic d_ci = 1'b0;
    logic d_rty = 1'b0;
    logic f_req = 1'b0;
    logic [31:0] f_addr = 32'h0;
    logic f_ci = 1'b0;
    logic f_rty = 1'b0;
    logic d_done, d_retried, d_busy, f_done, f_retried, hit, perr;
    logic [31:0] s_addr;
    int failures = 0;
    int checks = 0;
    pbarb_if bus ();
    pbarb_dev pbarb_dev_i (.clk(clk), .arst_n(arst_n), .arb_internal(arb_internal),
        .usr_req(d_req), .usr_addr(d_addr), .usr_ci(d_ci), .usr_retry(d_rty), .usr_done(d_done),
        .usr_retried(d_retried), .usr_busy(d_busy), .slave_base(32'h8000_0000),
        .slave_mask(32'hf000_0000), .slave_hit(hit), .slave_addr(s_addr),
        .slave_parity_err(perr), .bus(bus.dev));
    pbarb_far pbarb_far_i (.clk(clk), .arst_n(arst_n), .arb_internal(arb_internal),
        .usr_req(f_req), .usr_addr(f_addr), .usr_ci(f_ci), .usr_retry(f_rty), .usr_done(f_done),
        .usr_retried(f_retried), .bus(bus.far));
    pbarb_props pbarb_props_i (.clk(clk), .arst_n(arst_n), .proc_address(bus.proc_address),
        .addr_parity(bus.addr_parity), .addr_ack_n(bus.addr_ack_n),
        .addr_retry_n(bus.addr_retry_n), .addr_bus_busy_n(bus.addr_bus_busy_n),
        .data_bus_busy_n(bus.data_bus_busy_n), .addr_grant1_n(bus.addr_grant1_n),
        .dev_addr_oe(bus.dev_addr_oe), .far_addr_oe(bus.far_addr_oe), .dev_abb_oe(bus.dev_abb_oe),
        .far_abb_oe(bus.far_abb_oe), .dev_dbb_oe(bus.dev_dbb_oe), .dev_ci_oe(bus.dev_ci_oe),
        .dev_gnt1_oe(bus.dev_gnt1_oe), .dev_req1_oe(bus.dev_req1_oe));
    always #20 clk = ~clk;

    function automatic logic [3:0] odd_par(input logic [31:0] a);
        return {~^a[7:0], ~^a[15:8], ~^a[23:16], ~^a[31:24]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset(input logic mode);
        arst_n = 1'b0;
        arb_internal = mode;
        repeat (16) @(negedge clk);
        chk(bus.dev_addr_oe, 32'h0);
        chk(bus.addr_bus_busy_n, 1'b1);
        chk(bus.dev_gnt1_oe, mode);
        chk(bus.dev_req1_oe, !mode);
        arst_n = 1'b1;
        @(negedge clk);
    endtask
    // Samples the wire while the bridge owns it, so parity is judged as a third party sees it.
    task automatic t_dev_master(input logic [31:0] a, input logic ci, input logic rty);
        logic [31:0] seen_a;
        logic [3:0] seen_p;
        logic seen_ci;
        logic got_rty;
        int n;
        seen_a = 32'hx;
        seen_p = 4'hx;
        seen_ci = 1'bx;
        got_rty = 1'b0;
        f_rty = rty;
        d_addr = a;
        d_ci = ci;
        d_req = 1'b1;
        @(negedge clk);
        d_req = 1'b0;
        chk(d_busy, 1'b1);
        for (n = 0; n < 200 && d_done !== 1'b1; n++) begin
            if (bus.dev_abb_oe === 1'b1) begin
                seen_a = bus.proc_address;
                seen_p = bus.addr_parity;
                seen_ci = bus.cache_inhibit_n;
            end
            if (d_retried === 1'b1) begin
                got_rty = 1'b1;
                f_rty = 1'b0;
            end
            @(negedge clk);
        end
        chk(d_done, 1'b1);
        chk(d_busy, 1'b0);
        chk(got_rty, rty);
        chk(seen_a, a);
        chk(seen_p, odd_par(a));
        chk(seen_ci, !ci);
        chk(bus.addr_grant_ext_n, 2'h3);
    endtask
    // A retry from the bridge's slave side must make the far end reissue the same tenure.
    task automatic t_far_master(input logic [31:0] a, input logic rty);
        int n;
        logic got_hit;
        logic got_rty;
        got_hit = 1'b0;
        got_rty = 1'b0;
        d_rty = rty;
        f_addr = a;
        f_req = 1'b1;
        @(negedge clk);
        f_req = 1'b0;
        for (n = 0; n < 200 && f_done !== 1'b1; n++) begin
            if (hit === 1'b1)
                got_hit = 1'b1;
            if (f_retried === 1'b1) begin
                got_rty = 1'b1;
                d_rty = 1'b0;
            end
            @(negedge clk);
        end
        chk(got_hit, 1'b1);
        chk(got_rty, rty);
        chk(s_addr, a);
        chk(perr, 1'b0);
        chk(f_done, 1'b1);
    endtask

    initial begin
        // Let every process reach its first wait, so the fall of reset is seen.
        #1;
        t_reset(1'b1);
        t_dev_master(32'h1234_5678, 1'b1, 1'b0);
        t_dev_master(32'hff00_0180, 1'b0, 1'b0);
        t_far_master(32'h8abc_def0, 1'b0);
        t_far_master(32'h8123_4567, 1'b1);
        t_dev_master(32'h0000_00ff, 1'b1, 1'b1);
        t_reset(1'b0);
        t_dev_master(32'h0f0f_1e1e, 1'b0, 1'b0);
        t_far_master(32'h8000_0003, 1'b1);
        t_dev_master(32'h7fff_fffe, 1'b0, 1'b1);
        report_and_stop();
    end
    initial begin
        #(40 * 20000);
        failures++;
        report_and_stop();
    end
endmodule
